// ===== design/irq_mask_status_read.sv
`timescale 1ns/100ps
module irq_mask_status_read
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // host i/o port
  input wire logic [15:0] ioAddr,
  input wire logic ioRead,
  input wire logic ioWrite,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  // acknowledge handshake
  input wire logic intAck,
  output logic [3:0] ackLevel,
  output logic cpuIntr,
  // request lines, index 2 is the cascade and unused
  input wire logic [15:0] irqLine,
  // non-maskable sources
  input wire logic [pic_pkg::NMI_SOURCES-1:0] nmiEvent,
  output logic nmiReq
);
  import pic_pkg::*;

  typedef struct packed
  {
    logic [7:0] pending;
    logic [7:0] prevLine;
    logic [7:0] inService;
    logic [7:0] mask;
    logic specialMask;
    logic readIsr;
    logic pollArmed;
    logic [1:0] initLeft;
    logic initDone;
  } ctl_s;

  typedef struct packed
  {
    ctl_s [1:0] ctl;
    logic [7:0] rdData;
    logic readPrev;
    logic pollHold;
    logic [3:0] ackLevel;
    logic nmiDisable;
    logic [NMI_SOURCES-1:0] nmiEnable;
  } top_s;

  top_s st;
  top_s next_st;

  logic [1:0][7:0] lines;
  logic [1:0][7:0] eligible;
  logic [1:0][7:0] blocked;
  logic [1:0] winFound;
  logic [1:0][2:0] winIdx;
  logic [1:0] isFound;
  logic [1:0][2:0] isIdx;
  logic secIntr;
  logic [NMI_SOURCES-1:0] nmiFlags;

  ////////////////////////////////////////////////////////////////////////////
  // per-controller eligibility and priority resolution
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_ctl
      // levels at or below the highest in-service level are withheld
      always_comb
      begin
        for (int i = 0; i < 8; i++)
          blocked[c][i] = |(st.ctl[c].inService & 8'((9'h2 << i) - 9'h1));
      end

      // mask applied ahead of the picker, nesting skipped in special mask mode
      assign eligible[c] = st.ctl[c].initDone
        ? (st.ctl[c].pending & ~st.ctl[c].mask
           & (st.ctl[c].specialMask ? 8'hff : ~blocked[c]))
        : 8'h00;

      prio_pick u_win
      (
        .vec(eligible[c]),
        .found(winFound[c]),
        .idx(winIdx[c])
      );

      prio_pick u_isr
      (
        .vec(st.ctl[c].inService),
        .found(isFound[c]),
        .idx(isIdx[c])
      );
    end
  endgenerate

  // secondary output feeds primary line 2
  assign secIntr = winFound[1];
  assign lines[1] = irqLine[15:8];
  assign lines[0] = {irqLine[7:3], secIntr, irqLine[1:0]};
  assign cpuIntr = winFound[0];

  ////////////////////////////////////////////////////////////////////////////
  // non-maskable request path, separate from the numbered lines
  nmi_gate #(.N(NMI_SOURCES)) u_nmi
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sourceEvent(nmiEvent),
    .sourceEnable(st.nmiEnable),
    .globalDisable(st.nmiDisable),
    .flags(nmiFlags),
    .nmiReq(nmiReq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [1:0] cmdHit;
    logic [1:0] dataHit;
    logic readStart;
    logic [7:0] rd;
    next_st = st;
    cmdHit = {ioAddr == SEC_CMD_ADDR, ioAddr == PRI_CMD_ADDR};
    dataHit = {ioAddr == SEC_DATA_ADDR, ioAddr == PRI_DATA_ADDR};
    readStart = ioRead && !st.readPrev;
    rd = 8'h00;
    next_st.readPrev = ioRead;

    for (int k = 0; k < 2; k++)
    begin
      // request capture, frozen between poll write and poll read
      if (!st.ctl[k].pollArmed)
      begin
        next_st.ctl[k].prevLine = lines[k];
        next_st.ctl[k].pending = st.ctl[k].pending | (lines[k] & ~st.ctl[k].prevLine);
        if (k == 0)
          next_st.ctl[k].pending[CASCADE_LINE] = secIntr;
      end

      // writes to the command port
      if (ioWrite && cmdHit[k])
      begin
        if (ioWrData[CMD_INIT_BIT])
        begin
          next_st.ctl[k].initLeft = INIT_FOLLOW;
          next_st.ctl[k].initDone = 1'b0;
          next_st.ctl[k].mask = MASK_RESET;
          next_st.ctl[k].inService = 8'h00;
          next_st.ctl[k].specialMask = 1'b0;
          next_st.ctl[k].readIsr = 1'b0;
          next_st.ctl[k].pollArmed = 1'b0;
        end
        else if (ioWrData[CMD_OP3_BIT])
        begin
          if (ioWrData[OP3_SPECIAL_MASK_SELECT_BIT])
            next_st.ctl[k].specialMask = ioWrData[OP3_SMM_BIT];
          if (ioWrData[OP3_POLL_BIT])
            next_st.ctl[k].pollArmed = 1'b1;
          if (ioWrData[OP3_RR_BIT])
            next_st.ctl[k].readIsr = ioWrData[OP3_RIS_BIT];
        end
        else if (ioWrData[7:5] == EOS_NONSPEC && isFound[k])
          next_st.ctl[k].inService[isIdx[k]] = 1'b0;
        else if (ioWrData[7:5] == EOS_SPEC)
          next_st.ctl[k].inService[ioWrData[2:0]] = 1'b0;
      end

      // writes to the data port: remaining init words, then the mask
      if (ioWrite && dataHit[k])
      begin
        if (st.ctl[k].initLeft != 2'h0)
        begin
          next_st.ctl[k].initLeft = st.ctl[k].initLeft - 2'h1;
          if (st.ctl[k].initLeft == 2'h1)
            next_st.ctl[k].initDone = 1'b1;
        end
        else
          next_st.ctl[k].mask = ioWrData;
      end
    end

    // hardware acknowledge; primary winner 2 passes it to the secondary
    if (intAck)
    begin
      if (winFound[0])
      begin
        next_st.ctl[0].pending[winIdx[0]] = 1'b0;
        next_st.ctl[0].inService[winIdx[0]] = 1'b1;
        next_st.ackLevel = {1'b0, winIdx[0]};
        if (winIdx[0] == CASCADE_LINE && winFound[1])
        begin
          next_st.ctl[1].pending[winIdx[1]] = 1'b0;
          next_st.ctl[1].inService[winIdx[1]] = 1'b1;
          next_st.ackLevel = {1'b1, winIdx[1]};
        end
      end
      else
        next_st.ackLevel = {1'b0, SPURIOUS_LEVEL};
    end

    // read data for the current cycle
    for (int k = 0; k < 2; k++)
    begin
      if (cmdHit[k])
        rd = st.ctl[k].readIsr ? st.ctl[k].inService : st.ctl[k].pending;
      if (dataHit[k])
        rd = st.ctl[k].mask;
    end
    if (ioAddr == PRI_DATA_ALIAS)
      rd = st.ctl[0].mask;
    if (ioAddr == NMI_CTRL_ADDR)
      rd = {st.nmiDisable, 7'h00};
    if (ioAddr == NMI_SRC_ADDR)
      rd = {nmiFlags, st.nmiEnable};

    // first cycle of a read on an armed controller acts as acknowledge
    for (int k = 0; k < 2; k++)
    begin
      if (readStart && (cmdHit[k] || dataHit[k]) && st.ctl[k].pollArmed)
      begin
        rd = {winFound[k], 4'h0, winIdx[k]};
        next_st.pollHold = 1'b1;
        next_st.ctl[k].pollArmed = 1'b0;
        if (winFound[k])
        begin
          next_st.ctl[k].pending[winIdx[k]] = 1'b0;
          next_st.ctl[k].inService[winIdx[k]] = 1'b1;
        end
      end
    end

    // poll data stands for the whole read; other reads track live state
    if (!ioRead)
      next_st.pollHold = 1'b0;
    if (ioRead && !(st.pollHold && !readStart))
      next_st.rdData = rd;
    else if (!ioRead)
      next_st.rdData = 8'h00;

    // non-maskable gate and source enables
    if (ioWrite && ioAddr == NMI_CTRL_ADDR)
      next_st.nmiDisable = ioWrData[NMI_GATE_BIT];
    if (ioWrite && ioAddr == NMI_SRC_ADDR)
      next_st.nmiEnable = ioWrData[NMI_SOURCES-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.ctl[0].mask <= MASK_RESET;
      st.ctl[1].mask <= MASK_RESET;
      st.nmiEnable <= NMI_EN_RESET;
    end
    else
      st <= next_st;
  end

  assign ioRdData = st.rdData;
  assign ackLevel = st.ackLevel;
endmodule

// ===== common/pic_pkg.sv
package pic_pkg;
  // i/o port map
  localparam logic [15:0] PRI_CMD_ADDR = 16'h0020;
  localparam logic [15:0] PRI_DATA_ADDR = 16'h0021;
  localparam logic [15:0] PRI_DATA_ALIAS = 16'h0061;
  localparam logic [15:0] SEC_CMD_ADDR = 16'h00a0;
  localparam logic [15:0] SEC_DATA_ADDR = 16'h00a1;
  localparam logic [15:0] NMI_CTRL_ADDR = 16'h0070;
  localparam logic [15:0] NMI_SRC_ADDR = 16'h0461;
  // command port, poll data and non-maskable control field positions
  localparam int CMD_INIT_BIT = 4;
  localparam int CMD_OP3_BIT = 3;
  localparam int OP3_SPECIAL_MASK_SELECT_BIT = 6;
  localparam int OP3_SMM_BIT = 5;
  localparam int OP3_POLL_BIT = 2;
  localparam int OP3_RR_BIT = 1;
  localparam int OP3_RIS_BIT = 0;
  localparam int POLL_REQ_BIT = 7;
  localparam int NMI_GATE_BIT = 7;
  // end-of-service command codes in bits 7:5
  localparam logic [2:0] EOS_NONSPEC = 3'h1;
  localparam logic [2:0] EOS_SPEC = 3'h3;
  // init words after the first one
  localparam logic [1:0] INIT_FOLLOW = 2'h3;
  // cascade input of the primary controller
  localparam logic [2:0] CASCADE_LINE = 3'h2;
  localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
  // reset values and non-maskable source count
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [3:0] NMI_EN_RESET = 4'h0;
  localparam int NMI_SOURCES = 4;
endpackage

// ===== design/prio_pick.sv
`timescale 1ns/100ps
// finds the lowest set index, which is the highest priority
module prio_pick
(
  // vector in
  input wire logic [7:0] vec,
  // result
  output logic found,
  output logic [2:0] idx
);
  always_comb
  begin
    found = 1'b0;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (vec[i])
      begin
        found = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule

// ===== design/nmi_gate.sv
`timescale 1ns/100ps
module nmi_gate
#(
  parameter int N = 4
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // sources and enables
  input wire logic [N-1:0] sourceEvent,
  input wire logic [N-1:0] sourceEnable,
  input wire logic globalDisable,
  // status and request
  output logic [N-1:0] flags,
  output logic nmiReq
);
  typedef struct packed
  {
    logic [N-1:0] flags;
    logic req;
  } gate_s;
  gate_s st;
  gate_s next_st;

  // flags stick; only a per-source disable clears them, the global gate does not
  always_comb
  begin
    next_st.flags = (st.flags | sourceEvent) & sourceEnable;
    next_st.req = |st.flags && !globalDisable;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign flags = st.flags;
  assign nmiReq = st.req;
endmodule

// ===== verif/host_model.sv
`timescale 1ns/100ps
// processor side: i/o port cycles and acknowledge pulses
module host_model
(
  // clock
  input wire logic sys_clk,
  // i/o port
  output logic [15:0] ioAddr = 16'h0,
  output logic ioRead = 1'b0,
  output logic ioWrite = 1'b0,
  output logic [7:0] ioWrData = 8'h0,
  input wire logic [7:0] ioRdData,
  // acknowledge
  output logic intAck = 1'b0,
  input wire logic [3:0] ackLevel
);
  // one-cycle write strobe, data inverted once released
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ioAddr <= a;
    ioWrData <= d;
    ioWrite <= 1'b1;
    @(posedge sys_clk);
    ioWrite <= 1'b0;
    ioWrData <= ~d;
  endtask
  // read held until the answer is taken
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = ioRdData;
    @(posedge sys_clk);
    ioRead <= 1'b0;
  endtask
  // single acknowledge pulse, level taken after it lands
  task automatic ack(output logic [3:0] l);
    @(posedge sys_clk);
    intAck <= 1'b1;
    @(posedge sys_clk);
    intAck <= 1'b0;
    @(negedge sys_clk);
    l = ackLevel;
  endtask
  // command word then three data words
  task automatic init(input logic [15:0] c);
    wr(c, 8'h11);
    repeat (3) wr(c + 16'h1, 8'h01);
  endtask
  // op word three choosing the status register
  task automatic sel(input logic [15:0] c, input logic read_select_bit);
    wr(c, {7'h05, read_select_bit});
  endtask
endmodule

// ===== verif/irq_mask_status_read_props.sv
`timescale 1ns/100ps
module irq_mask_status_read_props
import pic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // host i/o port
  input wire logic [15:0] ioAddr,
  input wire logic ioRead,
  input wire logic ioWrite,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  // acknowledge
  input wire logic intAck,
  input wire logic [3:0] ackLevel,
  input wire logic cpuIntr,
  // requests
  input wire logic [15:0] irqLine,
  input wire logic [NMI_SOURCES-1:0] nmiEvent,
  input wire logic nmiReq
);
  typedef struct packed {logic [2:0] cnt; logic [7:0] mask;} shadow_s;
  shadow_s st;
  shadow_s next_st;
  logic mapped;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // decode of every mapped port
  assign mapped = ioAddr inside {PRI_CMD_ADDR, PRI_DATA_ADDR, PRI_DATA_ALIAS, SEC_CMD_ADDR, SEC_DATA_ADDR,
    NMI_CTRL_ADDR, NMI_SRC_ADDR};
  // primary init word count and mask copy
  always_comb
  begin
    next_st = st;
    if (ioWrite && ioAddr == PRI_CMD_ADDR && ioWrData[CMD_INIT_BIT])
      next_st = {3'h1, MASK_RESET};
    else if (ioWrite && ioAddr == PRI_DATA_ADDR && st.cnt == 3'h4)
      next_st.mask = ioWrData;
    else if (ioWrite && ioAddr == PRI_DATA_ADDR && st.cnt != 3'h0)
      next_st.cnt = st.cnt + 3'h1;
  end
  // shadow register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= {3'h0, MASK_RESET};
    else
      st <= next_st;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_read_idle_zero: assert property (!ioRead |=> ioRdData == 8'h00)
    else $error("read data not cleared");
  a_unmapped_zero: assert property (ioRead && !mapped |=> ioRdData == 8'h00)
    else $error("unmapped read not zero");
  a_mask_read_back: assert property (ioRead && st.cnt == 3'h4 && (ioAddr == PRI_DATA_ADDR ||
    ioAddr == PRI_DATA_ALIAS) |=> ioRdData == st.mask)
    else $error("mask read wrong");
  a_nmi_gate_off: assert property (ioWrite && ioAddr == NMI_CTRL_ADDR && ioWrData[NMI_GATE_BIT] |-> ##2 !nmiReq)
    else $error("gated request still high");
  a_ack_level_hold: assert property (!intAck |=> $stable(ackLevel))
    else $error("ack level moved");
  a_ack_spurious: assert property (intAck && !cpuIntr |=> ackLevel == {1'b0, SPURIOUS_LEVEL})
    else $error("idle ack not spurious");
  a_init_quiet: assert property (cpuIntr |-> st.cnt == 3'h4)
    else $error("request before init");
  a_mask_all_quiet: assert property (st.mask == 8'hff |-> !cpuIntr)
    else $error("masked request passed");
  c_ack_taken: cover property (intAck && cpuIntr);
  c_poll_cmd: cover property (ioWrite && ioAddr == PRI_CMD_ADDR && ioWrData[OP3_POLL_BIT]);
  c_nmi_rise: cover property ($rose(nmiReq));
endmodule
bind irq_mask_status_read irq_mask_status_read_props props (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite), .ioWrData(ioWrData), .ioRdData(ioRdData),
  .intAck(intAck), .ackLevel(ackLevel), .cpuIntr(cpuIntr), .irqLine(irqLine), .nmiEvent(nmiEvent),
  .nmiReq(nmiReq));

// ===== verif/tb_irq_mask_status_read.sv
`timescale 1ns/100ps
module tb_irq_mask_status_read;
  import pic_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] ioAddr;
  logic ioRead, ioWrite, intAck, cpuIntr, nmiReq;
  logic [7:0] ioWrData, ioRdData, d;
  logic [3:0] ackLevel, lv;
  logic [15:0] irqLine = 16'h0;
  logic [3:0] nmiEvent = 4'h0;
  int fails = 0;
  int numChecks = 0;
  int cyc = 0;
  // clock
  always #12.5 sys_clk = ~sys_clk;
  // host and block
  host_model h (.sys_clk(sys_clk), .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .intAck(intAck), .ackLevel(ackLevel));
  irq_mask_status_read uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ioAddr(ioAddr), .ioRead(ioRead),
    .ioWrite(ioWrite), .ioWrData(ioWrData), .ioRdData(ioRdData), .intAck(intAck), .ackLevel(ackLevel),
    .cpuIntr(cpuIntr), .irqLine(irqLine), .nmiEvent(nmiEvent), .nmiReq(nmiReq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (fails == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    numChecks++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string n);
    h.rd(a, d);
    chk(n, e, d);
  endtask
  task automatic ci(input logic e);
    @(negedge sys_clk);
    chk("cpuIntr", {7'h0, e}, {7'h0, cpuIntr});
  endtask
  task automatic ak(input logic [3:0] e);
    h.ack(lv);
    chk("ackLevel", {4'h0, e}, {4'h0, lv});
  endtask
  task automatic line(input int i, input logic v);
    @(posedge sys_clk);
    irqLine[i] <= v;
    repeat (2) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_mask;
    h.wr(PRI_DATA_ADDR, 8'h5a);
    h.wr(PRI_DATA_ALIAS, 8'hff);
    rdc(PRI_DATA_ADDR, 8'h5a, "mask");
    rdc(PRI_DATA_ALIAS, 8'h5a, "mask");
    rdc(16'h0300, 8'h00, "unmapped");
  endtask
  task automatic s_req;
    h.wr(PRI_DATA_ADDR, 8'h20);
    line(5, 1'b1);
    ci(1'b0);
    rdc(PRI_CMD_ADDR, 8'h20, "pending");
    h.wr(PRI_DATA_ADDR, 8'h00);
    ci(1'b1);
    ak(4'h5);
    h.sel(PRI_CMD_ADDR, 1'b1);
    rdc(PRI_CMD_ADDR, 8'h20, "inService");
    rdc(PRI_CMD_ADDR, 8'h20, "inService");
    h.sel(PRI_CMD_ADDR, 1'b0);
    rdc(PRI_CMD_ADDR, 8'h00, "pending");
  endtask
  task automatic s_nest;
    line(6, 1'b1);
    ci(1'b0);
    h.wr(PRI_CMD_ADDR, 8'h68);
    ci(1'b1);
    h.wr(PRI_CMD_ADDR, 8'h28);
    ci(1'b1);
    h.wr(PRI_CMD_ADDR, 8'h48);
    ci(1'b0);
    line(3, 1'b1);
    ci(1'b1);
    ak(4'h3);
    repeat (2) h.wr(PRI_CMD_ADDR, 8'h20);
    ci(1'b1);
    ak(4'h6);
    h.wr(PRI_CMD_ADDR, 8'h20);
  endtask
  task automatic s_casc;
    h.wr(PRI_DATA_ADDR, 8'h04);
    line(10, 1'b1);
    ci(1'b0);
    h.wr(PRI_DATA_ADDR, 8'hff);
    h.wr(PRI_DATA_ADDR, 8'h00);
    ci(1'b1);
    ak(4'ha);
    h.wr(SEC_CMD_ADDR, 8'h62);
    h.sel(SEC_CMD_ADDR, 1'b1);
    rdc(SEC_CMD_ADDR, 8'h00, "secInService");
    h.wr(PRI_CMD_ADDR, 8'h20);
  endtask
  task automatic s_poll;
    line(4, 1'b1);
    h.wr(PRI_CMD_ADDR, 8'h0e);
    rdc(PRI_CMD_ADDR, 8'h84, "poll");
    h.sel(PRI_CMD_ADDR, 1'b1);
    rdc(PRI_CMD_ADDR, 8'h10, "inService");
    h.wr(PRI_CMD_ADDR, 8'h20);
    ak({1'b0, SPURIOUS_LEVEL});
  endtask
  task automatic s_nmi;
    h.wr(NMI_SRC_ADDR, 8'h01);
    @(posedge sys_clk);
    nmiEvent <= 4'h1;
    @(posedge sys_clk);
    nmiEvent <= 4'h0;
    repeat (2) @(posedge sys_clk);
    ci(1'b0);
    chk("nmiReq", 8'h01, {7'h0, nmiReq});
    h.wr(NMI_CTRL_ADDR, 8'h80);
    rdc(NMI_SRC_ADDR, 8'h11, "nmiFlags");
    chk("nmiReq", 8'h00, {7'h0, nmiReq});
    h.wr(NMI_CTRL_ADDR, 8'h00);
    repeat (2) @(posedge sys_clk);
    ci(1'b0);
    chk("nmiReq", 8'h01, {7'h0, nmiReq});
  endtask
  task automatic s_reinit;
    line(1, 1'b1);
    ak(4'h1);
    line(0, 1'b1);
    h.wr(PRI_DATA_ADDR, 8'h33);
    h.init(PRI_CMD_ADDR);
    rdc(PRI_DATA_ADDR, MASK_RESET, "mask");
    rdc(PRI_CMD_ADDR, 8'h01, "pending");
    h.sel(PRI_CMD_ADDR, 1'b1);
    rdc(PRI_CMD_ADDR, 8'h00, "inService");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      conclude;
    end
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    h.init(PRI_CMD_ADDR);
    h.init(SEC_CMD_ADDR);
    s_mask;
    s_req;
    s_nest;
    s_casc;
    s_poll;
    s_nmi;
    s_reinit;
    conclude;
  end
endmodule
